// ===== logic/rcl_pkg.sv
package rcl_pkg;

  // ==========================================================
  // Register map and field layout
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_STAT    = 4'h4;
  localparam logic [3:0]  OFS_MASK    = 4'h8;
  localparam logic [3:0]  OFS_STATE   = 4'hC;

  localparam int          CTRL_BYP    = 0;
  localparam int          CTRL_MUTE   = 1;
  localparam int          CTRL_W      = 2;

  localparam int          EV_LOCK_UP  = 0;
  localparam int          EV_LOCK_DN  = 1;
  localparam int          EV_RATE_CHG = 2;
  localparam int          EV_UNSUP    = 3;
  localparam int          EV_W        = 4;

  localparam int          ST_LOCK     = 0;
  localparam int          ST_RATE     = 1;
  localparam int          ST_BYP      = 2;
  localparam int          ST_MUTE     = 3;
  localparam int          ST_SCO      = 4;
  localparam int          ST_W        = 5;

  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam logic [EV_W-1:0]   EV_RST   = 4'h0;

  // ==========================================================
  // Timing
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 100;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Pin levels
  localparam logic MUTE_LVL_P  = 1'b0;
  localparam logic MUTE_N_DFLT = 1'b1;
  localparam logic BYPASS_DFLT = 1'b0;
  localparam logic SCO_DFLT    = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    RATE_NONE,
    RATE_143,
    RATE_270,
    RATE_1483,
    RATE_1485,
    RATE_UNSUP
  } rcl_rate_t;

  typedef struct packed {
    logic sco;
    logic bypass;
    logic mute_n;
  } rcl_ctl_t;

  typedef struct packed {
    logic in_data;
    logic retimed;
    logic rec_clk;
  } rcl_stream_t;

  typedef struct packed {
    logic p;
    logic n;
  } rcl_diff_t;

  localparam rcl_ctl_t  CTL_DFLT = '{sco: SCO_DFLT, bypass: BYPASS_DFLT, mute_n: MUTE_N_DFLT};
  localparam rcl_diff_t DIFF_MUTED = '{p: MUTE_LVL_P, n: ~MUTE_LVL_P};

  function automatic logic rate_is_sd(input rcl_rate_t r);
    case (r)
      RATE_143,
      RATE_270: rate_is_sd = 1'b1;
      default:  rate_is_sd = 1'b0;
    endcase
  endfunction

  function automatic logic rate_ok(input rcl_rate_t r);
    case (r)
      RATE_143,
      RATE_270,
      RATE_1483,
      RATE_1485: rate_ok = 1'b1;
      default:   rate_ok = 1'b0;
    endcase
  endfunction

endpackage

// ===== logic/rcl_sync.sv
`timescale 1ns/1ps
module rcl_sync
  import rcl_pkg::*;
#(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic [WIDTH-1:0] q_unused_guard,
  output logic      [WIDTH-1:0] q
);

  // ==========================================================
  // Two-flop synchroniser; first stage feeds only the second
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// ===== logic/rcl_ctrl.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Unlocked, no bypass, unmuted: outputs carry the input without retiming.
// R2 - Locked to a supported rate, no bypass, unmuted: outputs carry retimed data.
// R3 - Bypass high and unmuted: input data passes unretimed whatever the lock.
// R4 - Lock indicator stays high in bypass while locked to a supported rate.
// R5 - Rate class flag high for the 270 and 143 Mbps rates.
// R6 - Rate class flag low for the 1483 and 1485 Mbps rates.
// R7 - Rate class flag is registered and valid only while locked.
// R8 - Unlocked forces the rate class flag low.
// R9 - Flag is unsettled briefly after lock changes; outside must not sample then.
// R10 - Clock select high puts the recovered clock on the secondary output.
// R11 - Clock select defaults low; secondary then copies the primary output.
// R12 - System supplies the 27 MHz reference clock.
// R13 - Mute low silences both outputs over bypass; pairs take opposite levels.
// R14 - Secondary in clock mode is muted whenever bypass is active.
// R15 - With bypass low, retiming is skipped when unlocked or rate unsupported.
// R16 - Mute defaults unmuted, bypass defaults low, through internal pulls.
// R17 - Mute, bypass and clock select are synchronised before steering outputs.
module rcl_ctrl
  import rcl_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire rcl_ctl_t          pin_ctl,
  input  wire rcl_ctl_t          pin_drv,
  input  wire logic              pll_locked,
  input  wire rcl_rate_t         rate_det,
  input  wire rcl_stream_t       stream,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   irq,
  output rcl_diff_t              primary_serial_out,
  output rcl_diff_t              secondary_serial_out,
  output logic                   lock_indicator,
  output logic                   rate_class_flag,
  output logic                   retime_active
);

  // ==========================================================
  // Pin defaults and synchronisation
  // Undriven pins resolve to their pull level
  wire rcl_ctl_t pin_eff;
  wire rcl_ctl_t ctl_s;
  assign pin_eff.mute_n = pin_drv.mute_n ? pin_ctl.mute_n : MUTE_N_DFLT; // R16
  assign pin_eff.bypass = pin_drv.bypass ? pin_ctl.bypass : BYPASS_DFLT; // R16
  assign pin_eff.sco    = pin_drv.sco    ? pin_ctl.sco    : SCO_DFLT;    // R11

  rcl_sync #(
    .WIDTH   ($bits(rcl_ctl_t)),
    .RST_VAL (CTL_DFLT)
  ) u_sync (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .d              (pin_eff),
    .q_unused_guard ('0),
    .q              (ctl_s)
  ); // R17

  // ==========================================================
  // Register file
  logic [CTRL_W-1:0] ctrl_reg;
  logic [EV_W-1:0]   stat_reg;
  logic [EV_W-1:0]   stat_next;
  logic [EV_W-1:0]   mask_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  wire hit_ctrl  = (addr == OFS_CTRL);
  wire hit_stat  = (addr == OFS_STAT);
  wire hit_mask  = (addr == OFS_MASK);
  wire hit_state = (addr == OFS_STATE);

  // ==========================================================
  // Effective controls
  wire lock_now  = pll_locked && rate_ok(rate_det);
  wire muted     = !ctl_s.mute_n || ctrl_reg[CTRL_MUTE];            // R13
  wire byp_force = ctl_s.bypass || ctrl_reg[CTRL_BYP];
  wire byp_act   = byp_force || !lock_now;                          // R15
  wire sco_mode  = ctl_s.sco;

  // ==========================================================
  // Lock tracking; rate flag blanked one cycle behind the settling state
  typedef enum logic [1:0] {
    LK_DOWN,
    LK_SETTLE,
    LK_UP
  } rcl_lk_t;

  localparam int          CNT_W   = $clog2(SETTLE + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE - 1);

  rcl_lk_t          lk_reg;
  rcl_lk_t          lk_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             lock_ind_reg;
  logic             rate_reg;
  logic             rate_next;
  logic             sd_seen_reg;

  // Reference is the class of the previous edge: the flag itself is low
  // on entry to UP and would restart settling on every SD lock
  wire class_moved = rate_is_sd(rate_det) != sd_seen_reg;

  always_comb begin
    lk_next  = lk_reg;
    cnt_next = '0;
    case (lk_reg)
      LK_DOWN: begin
        if (lock_now) begin
          lk_next = LK_SETTLE;
        end
      end
      LK_SETTLE: begin
        if (!lock_now) begin
          lk_next = LK_DOWN;
        end else if (cnt_reg == CNT_LAST) begin
          lk_next = LK_UP;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      LK_UP: begin
        if (!lock_now) begin
          lk_next = LK_DOWN;
        end else if (class_moved) begin
          lk_next = LK_SETTLE;
        end
      end
      default: lk_next = LK_DOWN;
    endcase
  end

  // Holding low one cycle behind settling gives the outside a defined level
  // instead of a half-updated class during a rate change
  assign rate_next = (lk_reg == LK_UP && lock_now) ? rate_is_sd(rate_det) : 1'b0; // R5 R6 R8 R9

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_reg       <= LK_DOWN;
      cnt_reg      <= '0;
      lock_ind_reg <= 1'b0;
      rate_reg     <= 1'b0;
      sd_seen_reg  <= 1'b0;
    end else begin
      lk_reg       <= lk_next;
      cnt_reg      <= cnt_next;
      lock_ind_reg <= lock_now; // R4
      rate_reg     <= rate_next; // R7
      sd_seen_reg  <= rate_is_sd(rate_det);
    end
  end

  // ==========================================================
  // Output multiplexers, registered
  rcl_diff_t pri_reg;
  rcl_diff_t sec_reg;
  wire       pri_bit = byp_act ? stream.in_data : stream.retimed; // R1 R2 R3
  wire rcl_diff_t pri_next = muted ? DIFF_MUTED : rcl_diff_t'{p: pri_bit, n: ~pri_bit}; // R13
  wire rcl_diff_t sec_clk  = (muted || byp_act) ? DIFF_MUTED   // R14
                             : rcl_diff_t'{p: stream.rec_clk, n: ~stream.rec_clk}; // R10
  wire rcl_diff_t sec_next = sco_mode ? sec_clk : pri_next; // R11

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pri_reg <= DIFF_MUTED;
      sec_reg <= DIFF_MUTED;
    end else begin
      pri_reg <= pri_next;
      sec_reg <= sec_next;
    end
  end

  // ==========================================================
  // Events and interrupt
  logic [EV_W-1:0] ev;
  logic            unsup_reg;
  wire             unsup_now = pll_locked && !rate_ok(rate_det);

  assign ev[EV_LOCK_UP]  = lock_now && !lock_ind_reg;
  assign ev[EV_LOCK_DN]  = !lock_now && lock_ind_reg;
  assign ev[EV_RATE_CHG] = rate_next != rate_reg;
  assign ev[EV_UNSUP]    = unsup_now && !unsup_reg;

  // A new event in the clearing read's cycle survives
  assign stat_next = (stat_reg & ~((rd && hit_stat) ? {EV_W{1'b1}} : EV_RST)) | ev;

  // ==========================================================
  // Bus slave
  wire [ST_W-1:0] state_word = {sco_mode, muted, byp_act, rate_reg, lock_ind_reg};

  assign rdata_next = !rd       ? '0
                    : hit_ctrl  ? DATA_W'(ctrl_reg)
                    : hit_stat  ? DATA_W'(stat_reg)
                    : hit_mask  ? DATA_W'(mask_reg)
                    : hit_state ? DATA_W'(state_word)
                    : '0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= CTRL_RST;
      mask_reg  <= EV_RST;
      stat_reg  <= EV_RST;
      unsup_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_reg <= wdata[CTRL_W-1:0];
      end
      if (wr && hit_mask) begin
        mask_reg <= wdata[EV_W-1:0];
      end
      stat_reg  <= stat_next;
      unsup_reg <= unsup_now;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata                = rdata_reg;
  assign irq                  = |(stat_reg & mask_reg);
  assign primary_serial_out   = pri_reg;
  assign secondary_serial_out = sec_reg;
  assign lock_indicator       = lock_ind_reg;
  assign rate_class_flag      = rate_reg;
  assign retime_active        = !byp_act;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_unlock_pass: assert property ( // R1
    (!lock_now && !byp_force && !muted) |=> primary_serial_out.p == $past(stream.in_data))
    else $error("unlocked input not passed through");
  a_locked_retime: assert property ( // R2
    (lock_now && !byp_force && !muted) |=> primary_serial_out.p == $past(stream.retimed))
    else $error("retimed data missing while locked");
  a_force_bypass: assert property ( // R3
    (byp_force && !muted) |=> primary_serial_out.p == $past(stream.in_data))
    else $error("bypass did not pass input data");
  a_lock_in_bypass: assert property ( // R4
    (byp_force && lock_now) |=> lock_indicator)
    else $error("lock indicator dropped in bypass");
  a_rate_sd: assert property ( // R5
    (lk_reg == LK_UP && lock_now && rate_is_sd(rate_det)) |=> rate_class_flag)
    else $error("sd rate not flagged high");
  a_rate_hd: assert property ( // R6
    (lk_reg == LK_UP && !rate_is_sd(rate_det)) |=> !rate_class_flag)
    else $error("hd rate not flagged low");
  a_rate_unlock: assert property ( // R8
    !lock_now |=> !rate_class_flag && !lock_indicator)
    else $error("rate flag high while unlocked");
  a_rate_settle: assert property ( // R9
    $rose(lock_indicator) |-> (!rate_class_flag) [*8])
    else $error("rate flag not held low while settling");
  a_sco_clock: assert property ( // R10
    (sco_mode && !muted && !byp_act) |=> secondary_serial_out.p == $past(stream.rec_clk))
    else $error("recovered clock not on secondary output");
  a_sco_copy: assert property ( // R11
    !sco_mode |=> secondary_serial_out == primary_serial_out)
    else $error("secondary output is not a data copy");
  a_mute_both: assert property ( // R13
    muted |=> primary_serial_out == DIFF_MUTED && secondary_serial_out == DIFF_MUTED)
    else $error("outputs not muted");
  a_sco_bypass: assert property ( // R14
    (sco_mode && byp_act) |=> secondary_serial_out == DIFF_MUTED)
    else $error("clock output not muted in bypass");
  a_pin_default: assert property ( // R16
    (!pin_drv.mute_n && !pin_drv.bypass && !pin_drv.sco) |-> ##2 ctl_s == CTL_DFLT)
    else $error("undriven pins did not take pull levels");
  a_ctl_delay: assert property ( // R17
    pin_drv.bypass |-> ##2 ctl_s.bypass == $past(pin_ctl.bypass, 2))
    else $error("bypass not synchronised in two stages");
  a_stat_sticky: assert property (
    ev[EV_LOCK_DN] |=> stat_reg[EV_LOCK_DN])
    else $error("event lost from status");
  a_unsup_bypass: assert property ( // R15
    (pll_locked && !rate_ok(rate_det) && !muted)
      |=> primary_serial_out.p == $past(stream.in_data))
    else $error("unsupported rate not bypassed");
  a_rate_low_settle: assert property ( // R7
    (lk_reg != LK_UP) |=> !rate_class_flag)
    else $error("rate flag set outside lock");
  a_stat_clear: assert property (
    (rd && hit_stat && ev == EV_RST) |=> stat_reg == EV_RST)
    else $error("status not cleared by read");
  a_rdata_idle: assert property (
    !rd |=> rdata == '0)
    else $error("read data not idle");

  c_lock_up:   cover property ($rose(lock_indicator) ##[1:40] $rose(rate_class_flag));
  c_sco_clock: cover property (sco_mode && !muted && !byp_act);
  c_irq:       cover property ($rose(irq) ##[1:10] (rd && hit_stat));
  c_hd_switch: cover property (lock_indicator && $fell(rate_class_flag));

endmodule

// ===== sim/rcl_src_model.sv
`timescale 1ns/1ps
module rcl_src_model
  import rcl_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire logic      lock_cmd,
  input  wire rcl_rate_t rate_cmd,
  output logic           pll_locked,
  output rcl_rate_t      rate_det,
  output rcl_stream_t    stream
);
  integer      seed = 32'h6da71a7b;
  logic [31:0] rnd;
  // ==========================================================
  // Upstream source on the bench clock, standing in for the reference
  // Retimed is the inverse of the raw bit, so a wrong selection always shows
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stream     <= '0;
      pll_locked <= 1'b0;
      rate_det   <= RATE_NONE;
    end else begin
      rnd = $random(seed);
      stream.in_data <= rnd[0];
      stream.retimed <= ~rnd[0];
      stream.rec_clk <= ~stream.rec_clk;
      pll_locked     <= lock_cmd;
      rate_det       <= rate_cmd;
    end
  end
endmodule

// ===== sim/reclocker_control_logic_tb.sv
`timescale 1ns/1ps
module reclocker_control_logic_tb
  import rcl_pkg::*;
;
  logic        mclk, rst_n, lock_cmd, pll_locked, wr, rd, irq, look, rd_q;
  logic        lock_indicator, rate_class_flag, retime_active;
  rcl_ctl_t    pin_ctl, pin_drv;
  rcl_rate_t   rate_cmd, rate_det;
  rcl_stream_t stream, stream_q;
  rcl_diff_t   pso, sso;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, e, act, want, rnd;
  logic [31:0] exp_q[$];
  int          bad_count = 0;
  int          check_count = 0;
  integer      seed = 32'h6da71a7b;
  rcl_rate_t   rates[4] = '{RATE_143, RATE_1483, RATE_1485, RATE_270};
  logic        sd[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  rcl_src_model src (.mclk(mclk), .rst_n(rst_n), .lock_cmd(lock_cmd), .rate_cmd(rate_cmd),
                     .pll_locked(pll_locked), .rate_det(rate_det), .stream(stream));
  rcl_ctrl uut (.mclk(mclk), .rst_n(rst_n), .pin_ctl(pin_ctl), .pin_drv(pin_drv),
                .pll_locked(pll_locked), .rate_det(rate_det), .stream(stream), .addr(addr),
                .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
                .primary_serial_out(pso), .secondary_serial_out(sso),
                .lock_indicator(lock_indicator), .rate_class_flag(rate_class_flag),
                .retime_active(retime_active));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Source codes: 0 muted, 1 raw input, 2 retimed, 3 recovered clock
  function automatic rcl_diff_t src_of(input logic [1:0] c, input rcl_stream_t s);
    case (c)
      2'h0: src_of = DIFF_MUTED;
      2'h1: src_of = '{p: s.in_data, n: ~s.in_data};
      2'h2: src_of = '{p: s.retimed, n: ~s.retimed};
      default: src_of = '{p: s.rec_clk, n: ~s.rec_clk};
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Monitor: outputs are registered from the stream of the previous edge
  always @(posedge mclk) begin
    stream_q <= stream;
    rd_q     <= rd;
    if (rd_q || look) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("ERROR %0t: result with no expectation", $time);
      end else begin
        e    = exp_q.pop_front();
        act  = rd_q ? rdata : {24'h0, pso, sso, lock_indicator, rate_class_flag, irq,
                               retime_active};
        want = rd_q ? e : {24'h0, src_of(e[7:6], stream_q), src_of(e[5:4], stream_q), e[3:0]};
        check_count++;
        if (act !== want) begin
          bad_count++;
          $display("ERROR %0t: got %h want %h", $time, act, want);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("ERROR %0t: run did not finish", $time);
    tally_and_finish();
  end

  // ==========================================================
  // Drivers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] x);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(x);
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  // Expectation: primary src, secondary src, lock, rate flag, irq, retime
  task automatic look_at(input logic [1:0] p, input logic [1:0] s, input logic [3:0] f);
    repeat (4) begin
      @(posedge mclk);
      look <= 1'b1;
      exp_q.push_back({24'h0, p, s, f});
    end
    @(posedge mclk);
    look <= 1'b0;
  endtask

  initial begin
    rst_n    = 1'b0;
    pin_ctl  = '{sco: 1'b1, bypass: 1'b1, mute_n: 1'b0};
    pin_drv  = '0;
    lock_cmd = 1'b0;
    rate_cmd = RATE_NONE;
    addr     = 4'h0;
    wdata    = 32'h0;
    wr       = 1'b0;
    rd       = 1'b0;
    look     = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    tick(3);
    look_at(2'h1, 2'h1, 4'h0);
    rd_reg(4'h2, 32'h0);
    rnd = $random(seed);
    wr_reg(OFS_MASK, rnd);
    rd_reg(OFS_MASK, {28'h0, rnd[3:0]});
    wr_reg(OFS_MASK, 32'h1);
    lock_cmd <= 1'b1;
    rate_cmd <= RATE_270;
    tick(SETTLE_CYC + 4);
    look_at(2'h2, 2'h2, 4'hF);
    rd_reg(OFS_STAT, 32'h5);
    for (int i = 0; i < 4; i++) begin
      rate_cmd <= rates[i];
      tick(SETTLE_CYC + 4);
      look_at(2'h2, 2'h2, {1'b1, sd[i], 1'b0, 1'b1});
    end
    pin_drv.bypass <= 1'b1;
    tick(4);
    look_at(2'h1, 2'h1, 4'hC);
    pin_drv.sco <= 1'b1;
    tick(4);
    look_at(2'h1, 2'h0, 4'hC);
    pin_drv.bypass <= 1'b0;
    tick(4);
    look_at(2'h2, 2'h3, 4'hD);
    pin_drv <= '{sco: 1'b0, bypass: 1'b1, mute_n: 1'b1};
    tick(4);
    look_at(2'h0, 2'h0, 4'hC);
    pin_drv <= '0;
    wr_reg(OFS_CTRL, 32'h1);
    tick(4);
    look_at(2'h1, 2'h1, 4'hC);
    rd_reg(OFS_STATE, 32'h7);
    wr_reg(OFS_CTRL, 32'h2);
    tick(2);
    look_at(2'h0, 2'h0, 4'hD);
    rd_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_CTRL, 32'h0);
    wr_reg(OFS_MASK, 32'h8);
    rate_cmd <= RATE_UNSUP;
    tick(4);
    look_at(2'h1, 2'h1, 4'h2);
    rd_reg(OFS_STAT, 32'hE);
    lock_cmd <= 1'b0;
    rate_cmd <= RATE_NONE;
    tick(4);
    look_at(2'h1, 2'h1, 4'h0);
    tick(2);
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("ERROR %0t: expectations left unchecked", $time);
    end
    tally_and_finish();
  end
endmodule
